// file: design/cdst_pkg.sv
package cdst_pkg;
	// node counts: one lane per opposite-kind node, one bit per defendant
	localparam int NODES = 4;
	localparam int VCNT_W = 3;
	// timing in ns and derived cycle counts at 25 MHz
	localparam int CLK_PERIOD_NS = 40;
	localparam int WIN_OPEN_NS = 200;
	localparam int WIN_CLOSE_NS = 4000;
	localparam int UPSET_ABATE_NS = 1000000;
	localparam int WIN_OPEN_CYC = (WIN_OPEN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WIN_CLOSE_CYC = WIN_CLOSE_NS / CLK_PERIOD_NS;
	localparam int SETTLE_CYC = (UPSET_ABATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WCNT_W = 8;
	localparam int SCNT_W = 24;
	// values after reset, and the count of a single message
	localparam logic [NODES-1:0] VEC_RST = 4'h0;
	localparam logic [1:0] MSG_CNT_RST = 2'h0;
	localparam logic [1:0] MSG_CNT_ONE = 2'h1;

	typedef logic [NODES-1:0] cdst_vec_type;
	typedef logic [NODES-1:0][NODES-1:0] cdst_words_type;
	typedef enum logic [1:0] {
		ROUND_TWO = 2'h0,
		ROUND_THREE = 2'h1,
		ROUND_FOUR = 2'h2
	} cdst_round_type;
	typedef enum logic [2:0] {
		MODE_DETECT = 3'h0,
		MODE_JOIN_FIRST = 3'h1,
		MODE_JOIN_SECOND = 3'h2,
		MODE_INIT = 3'h3,
		MODE_PRESERVE = 3'h4
	} cdst_mode_type;
	typedef enum logic [1:0] {
		ST_CLEAR = 2'h0,
		ST_TEST = 2'h1,
		ST_OPER = 2'h3,
		ST_HALT = 2'h2
	} cdst_node_st_type;
	typedef enum logic [1:0] {
		RS_IDLE = 2'h0,
		RS_COLLECT = 2'h1,
		RS_EVAL = 2'h3
	} cdst_rnd_st_type;

	// number of set bits in a lane vector
	function automatic logic [VCNT_W-1:0] popcount(input cdst_vec_type v);
		logic [VCNT_W-1:0] n;
		n = '0;
		for (int i = 0; i < NODES; i++) begin
			n = n + VCNT_W'(v[i]);
		end
		return n;
	endfunction : popcount

	// strict majority of n voters
	function automatic logic is_majority(input logic [VCNT_W-1:0] cnt, input logic [VCNT_W-1:0] n);
		return {cnt, 1'b0} > {1'b0, n};
	endfunction : is_majority
endpackage : cdst_pkg

// file: design/cdst_lane_if.sv
`timescale 1ns/100ps
interface cdst_lane_if;
	import cdst_pkg::*;
	cdst_vec_type   eligible;
	cdst_vec_type   rx_error;
	cdst_words_type word;
	modport screen (output eligible, output rx_error, output word);
	modport core (input eligible, input rx_error, input word);
endinterface : cdst_lane_if

// file: design/cdst_screen.sv
`timescale 1ns/100ps
module cdst_screen
	import cdst_pkg::*;
(
	// clock and reset
	input  logic               clock,
	input  logic               srst,
	// round control
	input  logic               clear,
	input  logic               active,
	input  logic               window,
	// receive side
	input  cdst_vec_type       rx_valid,
	input  cdst_vec_type       rx_link_err,
	input  cdst_vec_type       rx_is_data,
	input  cdst_vec_type       trusted,
	input  cdst_words_type     rx_word,
	// lane results
	cdst_lane_if.screen        lane
);
	logic [NODES-1:0][1:0] msg_cnt_ff;
	cdst_vec_type          rx_err_ff;
	cdst_vec_type          bad_ff;
	cdst_words_type        word_ff;

	// message count per source, saturating at two
	always_ff @(posedge clock) begin
		for (int i = 0; i < NODES; i++) begin
			if (srst || clear) begin
				msg_cnt_ff[i] <= MSG_CNT_RST;
			end else if (active && rx_valid[i] && msg_cnt_ff[i] != 2'h2) begin
				msg_cnt_ff[i] <= msg_cnt_ff[i] + 2'h1;
			end
		end
	end

	// link and timing errors, and content that is not a data message
	always_ff @(posedge clock) begin
		if (srst || clear) begin
			rx_err_ff <= VEC_RST;
			bad_ff <= VEC_RST;
		end else if (active) begin
			rx_err_ff <= rx_err_ff | (rx_valid & (rx_link_err | {NODES{!window}}));
			bad_ff <= bad_ff | (rx_valid & ~rx_is_data);
		end
	end

	// keep the first word received from each source
	always_ff @(posedge clock) begin
		for (int i = 0; i < NODES; i++) begin
			if (srst || clear) begin
				word_ff[i] <= VEC_RST;
			end else if (active && rx_valid[i] && msg_cnt_ff[i] == MSG_CNT_RST) begin
				word_ff[i] <= rx_word[i];
			end
		end
	end

	// a voter needs exactly one clean message, data content and trust
	always_comb begin
		for (int i = 0; i < NODES; i++) begin
			lane.rx_error[i] = rx_err_ff[i] || msg_cnt_ff[i] != MSG_CNT_ONE;
		end
		lane.eligible = ~lane.rx_error & ~bad_ff & trusted;
		lane.word = word_ff;
	end
endmodule : cdst_screen

// file: design/cdst_vote.sv
`timescale 1ns/100ps
module cdst_vote
	import cdst_pkg::*;
(
	// lane results
	cdst_lane_if.core          lane,
	// vote results
	output cdst_vec_type       bit_vote,
	output cdst_vec_type       word_vote,
	output cdst_vec_type       mismatch,
	output logic [VCNT_W-1:0]  n_elig,
	output logic [VCNT_W-1:0]  agree_cnt
);
	cdst_vec_type col;
	cdst_vec_type same;

	// per-defendant majority over the eligible voters' accusation bits
	always_comb begin
		col = '0;
		n_elig = popcount(lane.eligible);
		for (int d = 0; d < NODES; d++) begin
			for (int v = 0; v < NODES; v++) begin
				col[v] = lane.word[v][d] & lane.eligible[v];
			end
			bit_vote[d] = is_majority(popcount(col), n_elig);
		end
	end

	// whole-word vote, first word with the largest support wins a tie
	always_comb begin
		same = '0;
		agree_cnt = '0;
		word_vote = '0;
		for (int v = 0; v < NODES; v++) begin
			for (int u = 0; u < NODES; u++) begin
				same[u] = lane.eligible[u] && lane.word[u] == lane.word[v];
			end
			if (lane.eligible[v] && popcount(same) > agree_cnt) begin
				agree_cnt = popcount(same);
				word_vote = lane.word[v];
			end
		end
		for (int v = 0; v < NODES; v++) begin
			mismatch[v] = lane.eligible[v] && lane.word[v] != word_vote;
		end
	end
endmodule : cdst_vote

// file: design/cdst_node.sv
`timescale 1ns/100ps
// Function
// - in round two managers check each interface message for link, window, count and content
// - managers drop interface voters with reception error, bad content or no trust
// - managers report a protocol failure when no interface voter is eligible
// - managers bit-vote each interface defendant over eligible voters' accusation bits
// - managers broadcast all per-defendant bit votes in a single message
// - in round three interface nodes screen manager messages the same way
// - interface nodes report a protocol failure when no manager voter is eligible
// - interface nodes take a whole-word majority vote over eligible managers
// - interface nodes flag every eligible manager whose word differs from the vote
// - a voted word without majority agreement is a protocol failure
// - interface nodes broadcast the voted word and hand it to the processing element
// - a voted vector convicting every interface node is a protocol failure
// - interface nodes check their own conviction against what their mode expects
// - in round four managers screen interface broadcasts and check for a voter
// - rounds never overlap: a single round engine accepts a new round only when idle
// - a failed self-test restarts self-test mode
// - a permanent fault keeps the node in self-test forever
// - on any failure drop off the bus and self-test for the full settling time
// - self-test is entered after power-on enable and after local or bus failure
// - entering self-test resets everything and disables the bus output
// - all prior state is discarded after any fault
// - self-test runs the whole settling interval before leaving
// - a reception error accuses the source node
// - a cross-lane mismatch accuses the source node
// - voter and majority check failures report a clique failure
module cdst_node
	import cdst_pkg::*;
#(
	parameter int SETTLE_CYCLES = SETTLE_CYC
) (
	// clock and reset
	input  logic               clock,
	input  logic               srst,
	// node identity and mode
	input  logic               node_is_manager,
	input  logic [1:0]         self_idx,
	input  cdst_mode_type      op_mode,
	// round control
	input  logic               round_start,
	input  cdst_round_type     round_sel,
	// received messages, one lane per opposite-kind node
	input  cdst_vec_type       rx_valid,
	input  cdst_vec_type       rx_link_err,
	input  cdst_vec_type       rx_is_data,
	input  cdst_words_type     rx_word,
	input  cdst_vec_type       trusted,
	// failure sources and self-test
	input  logic               power_on_en,
	input  logic               bus_fail,
	input  logic               local_fail_in,
	input  logic               test_fail,
	input  logic               test_perm_fault,
	// bus and processing element side
	output logic               tx_valid,
	output cdst_vec_type       tx_word,
	output logic               pe_valid,
	output cdst_vec_type       pe_word,
	output logic               accuse_valid,
	output cdst_vec_type       accuse,
	// failure reports and node state
	output logic               clique_fail,
	output logic               local_fail,
	output logic               bus_out_en,
	output logic               in_selftest,
	output logic               state_clear,
	output logic               enter_clique_detect
);
	localparam int EVAL_DLY = WIN_CLOSE_CYC + 2;

	cdst_lane_if lane ();

	logic              pwr_en_s1_ff;
	logic              pwr_en_s2_ff;
	cdst_node_st_type  node_st_ff;
	cdst_node_st_type  nxt_node_st;
	logic [SCNT_W-1:0] settle_cnt_ff;
	logic              settle_done;
	logic              enter_cd_ff;
	cdst_rnd_st_type   rnd_st_ff;
	cdst_rnd_st_type   nxt_rnd_st;
	cdst_round_type    sel_ff;
	logic [WCNT_W-1:0] win_cnt_ff;
	logic              oper;
	logic              role_ok;
	logic              accept;
	logic              collecting;
	logic              window;
	logic              eval;
	logic              flush;
	logic              fail_now;
	cdst_vec_type      bit_vote;
	cdst_vec_type      word_vote;
	cdst_vec_type      mismatch;
	logic [VCNT_W-1:0] n_elig;
	logic [VCNT_W-1:0] agree_cnt;
	logic              no_voter;
	logic              no_major;
	logic              all_conv;
	logic              self_conv;
	logic              self_local;
	logic              self_clique;
	logic              tx_valid_ff;
	cdst_vec_type      tx_word_ff;
	logic              pe_valid_ff;
	cdst_vec_type      pe_word_ff;
	logic              accuse_valid_ff;
	cdst_vec_type      accuse_ff;
	logic              clique_fail_ff;
	logic              local_fail_ff;

	// power-on enable comes from a pin
	always_ff @(posedge clock) begin
		if (srst) begin
			pwr_en_s1_ff <= 1'b0;
			pwr_en_s2_ff <= 1'b0;
		end else begin
			pwr_en_s1_ff <= power_on_en;
			pwr_en_s2_ff <= pwr_en_s1_ff;
		end
	end

	// any failure sends the node back to self-test
	assign fail_now = clique_fail_ff || local_fail_ff || bus_fail || local_fail_in || !pwr_en_s2_ff;
	assign settle_done = settle_cnt_ff == SCNT_W'(SETTLE_CYCLES - 1);

	// node mode: clear, self-test, operating, halted
	always_comb begin
		nxt_node_st = node_st_ff;
		unique case (node_st_ff)
			ST_CLEAR: begin
				if (pwr_en_s2_ff) begin
					nxt_node_st = ST_TEST;
				end
			end
			ST_TEST: begin
				if (test_perm_fault) begin
					nxt_node_st = ST_HALT;
				end else if (test_fail) begin
					nxt_node_st = ST_CLEAR;
				end else if (settle_done) begin
					nxt_node_st = ST_OPER;
				end
			end
			ST_OPER: begin
				if (fail_now) begin
					nxt_node_st = ST_CLEAR;
				end
			end
			ST_HALT: begin
				nxt_node_st = ST_HALT;
			end
		endcase
	end

	// node mode register
	always_ff @(posedge clock) begin
		if (srst) begin
			node_st_ff <= ST_CLEAR;
		end else begin
			node_st_ff <= nxt_node_st;
		end
	end

	// settling interval counter, restarted on every entry to self-test
	always_ff @(posedge clock) begin
		if (srst || node_st_ff != ST_TEST) begin
			settle_cnt_ff <= '0;
		end else if (!settle_done) begin
			settle_cnt_ff <= settle_cnt_ff + SCNT_W'(1);
		end
	end

	// one-cycle mark on leaving self-test
	always_ff @(posedge clock) begin
		if (srst) begin
			enter_cd_ff <= 1'b0;
		end else begin
			enter_cd_ff <= node_st_ff == ST_TEST && nxt_node_st == ST_OPER;
		end
	end

	// bus output only while operating; every non-operating mode drives the full reset
	assign oper = node_st_ff == ST_OPER;
	assign flush = !oper;
	assign bus_out_en = oper;
	assign in_selftest = !oper;
	assign state_clear = node_st_ff == ST_CLEAR;
	assign enter_clique_detect = enter_cd_ff;

	// managers run rounds two and four, interface nodes round three
	always_comb begin
		if (node_is_manager) begin
			role_ok = round_sel == ROUND_TWO || round_sel == ROUND_FOUR;
		end else begin
			role_ok = round_sel == ROUND_THREE;
		end
	end

	// a single engine for all rounds; a new round is accepted only while the engine is idle
	assign accept = round_start && oper && rnd_st_ff == RS_IDLE && role_ok;
	assign collecting = rnd_st_ff == RS_COLLECT;
	assign window = collecting && win_cnt_ff >= WCNT_W'(WIN_OPEN_CYC);
	assign eval = rnd_st_ff == RS_EVAL;

	// round sequencing: collect through the window, then evaluate once
	always_comb begin
		nxt_rnd_st = rnd_st_ff;
		unique case (rnd_st_ff)
			RS_IDLE: begin
				if (accept) begin
					nxt_rnd_st = RS_COLLECT;
				end
			end
			RS_COLLECT: begin
				if (win_cnt_ff == WCNT_W'(WIN_CLOSE_CYC)) begin
					nxt_rnd_st = RS_EVAL;
				end
			end
			RS_EVAL: begin
				nxt_rnd_st = RS_IDLE;
			end
			default: begin
				nxt_rnd_st = RS_IDLE;
			end
		endcase
		if (flush) begin
			nxt_rnd_st = RS_IDLE;
		end
	end

	// round state and local-time window counter
	always_ff @(posedge clock) begin
		if (srst) begin
			rnd_st_ff <= RS_IDLE;
			win_cnt_ff <= '0;
			sel_ff <= ROUND_TWO;
		end else begin
			rnd_st_ff <= nxt_rnd_st;
			if (accept) begin
				win_cnt_ff <= '0;
				sel_ff <= round_sel;
			end else if (collecting) begin
				win_cnt_ff <= win_cnt_ff + WCNT_W'(1);
			end
		end
	end

	// reception screening per lane
	cdst_screen u_screen (
		.clock       (clock),
		.srst        (srst),
		.clear       (accept || flush),
		.active      (collecting),
		.window      (window),
		.rx_valid    (rx_valid),
		.rx_link_err (rx_link_err),
		.rx_is_data  (rx_is_data),
		.trusted     (trusted),
		.rx_word     (rx_word),
		.lane        (lane)
	);

	// bit vote and word vote over the eligible lanes
	cdst_vote u_vote (
		.lane      (lane),
		.bit_vote  (bit_vote),
		.word_vote (word_vote),
		.mismatch  (mismatch),
		.n_elig    (n_elig),
		.agree_cnt (agree_cnt)
	);

	// round checks on the vote results
	always_comb begin
		no_voter = n_elig == '0;
		no_major = !is_majority(agree_cnt, n_elig);
		all_conv = &word_vote;
		self_conv = word_vote[self_idx];
		self_clique = op_mode == MODE_DETECT && self_conv;
		if (op_mode == MODE_JOIN_FIRST) begin
			self_local = !self_conv;
		end else begin
			self_local = op_mode != MODE_DETECT && self_conv;
		end
	end

	// evaluation: accusations, failures, broadcast and delivery
	always_ff @(posedge clock) begin
		if (srst || flush) begin
			tx_valid_ff <= 1'b0;
			tx_word_ff <= VEC_RST;
			pe_valid_ff <= 1'b0;
			pe_word_ff <= VEC_RST;
			accuse_valid_ff <= 1'b0;
			accuse_ff <= VEC_RST;
			clique_fail_ff <= 1'b0;
			local_fail_ff <= 1'b0;
		end else begin
			tx_valid_ff <= 1'b0;
			pe_valid_ff <= 1'b0;
			accuse_valid_ff <= 1'b0;
			clique_fail_ff <= 1'b0;
			local_fail_ff <= 1'b0;
			if (eval) begin
				accuse_valid_ff <= 1'b1;
				if (sel_ff == ROUND_THREE) begin
					accuse_ff <= lane.rx_error | mismatch;
					clique_fail_ff <= no_voter || no_major || all_conv || self_clique;
					local_fail_ff <= !no_voter && self_local;
				end else begin
					accuse_ff <= lane.rx_error;
					clique_fail_ff <= no_voter;
				end
				if (!no_voter && sel_ff == ROUND_TWO) begin
					tx_valid_ff <= 1'b1;
					tx_word_ff <= bit_vote;
				end
				if (!no_voter && sel_ff == ROUND_THREE) begin
					tx_valid_ff <= 1'b1;
					tx_word_ff <= word_vote;
					pe_valid_ff <= 1'b1;
					pe_word_ff <= word_vote;
				end
			end
		end
	end

	// registered outputs
	assign tx_valid = tx_valid_ff;
	assign tx_word = tx_word_ff;
	assign pe_valid = pe_valid_ff;
	assign pe_word = pe_word_ff;
	assign accuse_valid = accuse_valid_ff;
	assign accuse = accuse_ff;
	assign clique_fail = clique_fail_ff;
	assign local_fail = local_fail_ff;

	// checks on the node's own behaviour
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (srst);

	// a failure before the evaluate cycle flushes the results, so only operating evaluations count
	sequence s_eval_none;
		eval && oper && n_elig == '0;
	endsequence
	sequence s_eval_r2;
		eval && oper && sel_ff == ROUND_TWO && n_elig != '0;
	endsequence
	sequence s_eval_r3;
		eval && oper && sel_ff == ROUND_THREE && n_elig != '0;
	endsequence

	settle_full_a: assert property (
		$rose(bus_out_en) |-> $past(settle_cnt_ff) == SCNT_W'(SETTLE_CYCLES - 1))
		else $error("bus output enabled before settling ended");
	fail_drop_a: assert property (
		(oper && fail_now) |=> state_clear && !bus_out_en && !tx_valid)
		else $error("failure did not drop the node off the bus");
	test_restart_a: assert property (
		(node_st_ff == ST_TEST && test_fail && !test_perm_fault) |=> node_st_ff == ST_CLEAR)
		else $error("failed self-test did not restart");
	perm_stay_a: assert property (
		(node_st_ff == ST_TEST && test_perm_fault) |=> (in_selftest && !bus_out_en)[*8])
		else $error("permanent fault let the node leave self-test");
	no_voter_a: assert property (
		s_eval_none |=> clique_fail && !tx_valid && accuse_valid)
		else $error("empty voter set not reported");
	bit_bcast_a: assert property (
		s_eval_r2 |=> tx_valid && tx_word == $past(bit_vote) && !pe_valid)
		else $error("bit votes not broadcast");
	majority_a: assert property (
		s_eval_r3 ##0 !is_majority(agree_cnt, n_elig) |=> clique_fail)
		else $error("missing majority not reported");
	all_conv_a: assert property (
		s_eval_r3 ##0 (&word_vote) |=> clique_fail && pe_word == '1)
		else $error("all-convicting vector not reported");
	pe_same_a: assert property (
		pe_valid |-> tx_valid && pe_word == tx_word)
		else $error("processing element got a different word");
	cross_lane_a: assert property (
		s_eval_r3 ##0 (mismatch != '0) |=> accuse_valid && (accuse & $past(mismatch)) == $past(mismatch))
		else $error("cross-lane mismatch not accused");
	round_len_a: assert property (
		accept |-> ##EVAL_DLY (eval || !oper))
		else $error("round did not evaluate at window end");
endmodule : cdst_node

// file: sim/cdst_far_nodes.sv
`timescale 1ns/100ps
module cdst_far_nodes
	import cdst_pkg::*;
(
	// clock and round trigger
	input  logic                  clock,
	input  logic                  start,
	// per-lane script: sample edge of first message, message count, faults, words
	input  logic [NODES-1:0][7:0] dly,
	input  logic [NODES-1:0][1:0] cnt,
	input  cdst_vec_type          bad_link,
	input  cdst_vec_type          is_data,
	input  cdst_words_type        word,
	// message lanes towards the node
	output cdst_vec_type          rx_valid = '0,
	output cdst_vec_type          rx_link_err = '0,
	output cdst_vec_type          rx_is_data = '0,
	output cdst_words_type        rx_word = '0
);
	logic [7:0] t_ff = 8'h0;

	// local time of the far side, edges since the round trigger
	always_ff @(posedge clock) begin
		if (start)
			t_ff <= 8'h1;
		else if (t_ff != 8'h0 && t_ff < 8'h78)
			t_ff <= t_ff + 8'h1;
		else
			t_ff <= 8'h0;
	end

	// none, one or two messages per lane; between messages the lanes carry a changing pattern
	always_ff @(posedge clock) begin
		for (int i = 0; i < NODES; i++) begin
			if (t_ff != 8'h0 && cnt[i] != 2'h0 &&
			    (t_ff + 8'h1 == dly[i] || (cnt[i] == 2'h2 && t_ff == dly[i]))) begin
				rx_valid[i]    <= 1'b1;
				rx_link_err[i] <= bad_link[i];
				rx_is_data[i]  <= is_data[i];
				rx_word[i]     <= word[i];
			end else begin
				rx_valid[i]    <= 1'b0;
				rx_link_err[i] <= ~rx_link_err[i];
				rx_is_data[i]  <= ~rx_is_data[i];
				rx_word[i]     <= ~rx_word[i];
			end
		end
	end
endmodule : cdst_far_nodes

// file: sim/cdst_node_tb_top.sv
`timescale 1ns/100ps
module cdst_node_tb_top
	import cdst_pkg::*;
;
	localparam int SETTLE = 20;
	localparam logic [31:0] DL = 32'h0a0a0a0a;
	logic               clock, srst, node_is_manager, round_start, power_on_en;
	logic               bus_fail, local_fail_in, test_fail, test_perm_fault;
	logic               tx_valid, pe_valid, accuse_valid, clique_fail, local_fail;
	logic               bus_out_en, in_selftest, state_clear, enter_clique_detect;
	logic [1:0]         self_idx;
	cdst_mode_type      op_mode;
	cdst_round_type     round_sel;
	cdst_vec_type       trusted, rx_valid, rx_link_err, rx_is_data, tx_word, pe_word, accuse;
	cdst_vec_type       bad_link, is_data;
	cdst_words_type     rx_word, word;
	logic [3:0][7:0]    dly;
	logic [3:0][1:0]    cnt;
	int                 n_errors = 0;
	int                 n_checks = 0;

	// design under test, shortened settling interval
	cdst_node #(.SETTLE_CYCLES(SETTLE)) cdst_node_inst (.clock, .srst, .node_is_manager, .self_idx, .op_mode,
		.round_start, .round_sel, .rx_valid, .rx_link_err, .rx_is_data, .rx_word, .trusted, .power_on_en,
		.bus_fail, .local_fail_in, .test_fail, .test_perm_fault, .tx_valid, .tx_word, .pe_valid, .pe_word,
		.accuse_valid, .accuse, .clique_fail, .local_fail, .bus_out_en, .in_selftest, .state_clear,
		.enter_clique_detect);

	// opposite-kind nodes
	cdst_far_nodes cdst_far_nodes_inst (.clock, .start(round_start), .dly, .cnt, .bad_link, .is_data, .word,
		.rx_valid, .rx_link_err, .rx_is_data, .rx_word);

	// 25 MHz clock
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : chk

	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_sim

	// waits out self-test and checks the way back onto the bus
	task automatic wait_oper();
		int n, k;
		n = 0;
		for (k = 0; k < 300 && bus_out_en !== 1'b1; k++) begin
			@(negedge clock);
			if (in_selftest === 1'b1 && state_clear === 1'b0)
				n++;
		end
		chk("settle length", n >= SETTLE, 1);
		chk("clique detect entry", {enter_clique_detect, in_selftest}, 2'h2);
	endtask : wait_oper

	task automatic do_reset(input logic role);
		@(posedge clock);
		srst <= 1'b1;
		node_is_manager <= role;
		repeat (10) @(posedge clock);
		srst <= 1'b0;
		@(negedge clock);
		chk("reset state", {bus_out_en, in_selftest, state_clear}, 3'h3);
		wait_oper();
	endtask : do_reset

	// after a failure: drop off the bus, clear, self-test, come back
	task automatic restart();
		int n;
		for (n = 0; n < 4 && bus_out_en !== 1'b0; n++)
			@(negedge clock);
		chk("clear on fault", {state_clear, bus_out_en}, 2'h2);
		wait_oper();
		// results are flushed one edge after the drop; nothing may survive into operation
		chk("state discarded", {tx_word, pe_word, accuse}, 0);
	endtask : restart

	task automatic plan(input cdst_words_type w, input cdst_vec_type bl, dat, tr, input logic [31:0] d,
		input logic [7:0] c);
		@(posedge clock);
		word <= w;
		bad_link <= bl;
		is_data <= dat;
		trusted <= tr;
		dly <= d;
		cnt <= c;
	endtask : plan

	task automatic round(input cdst_round_type sel, input string what, input logic [11:0] exp);
		int n;
		@(posedge clock);
		round_start <= 1'b1;
		round_sel <= sel;
		@(posedge clock);
		round_start <= 1'b0;
		for (n = 0; n < 200; n++) begin
			@(negedge clock);
			if (accuse_valid === 1'b1)
				break;
			@(posedge clock);
		end
		chk("answer edge", n, 102);
		chk(what, {tx_valid, pe_valid, clique_fail, local_fail, tx_word, accuse}, exp);
		if (sel == ROUND_THREE && tx_valid === 1'b1)
			chk("pe word", pe_word, tx_word);
		$display("done %s", what);
	endtask : round

	task automatic kick(input logic loc);
		@(posedge clock);
		if (loc)
			local_fail_in <= 1'b1;
		else
			bus_fail <= 1'b1;
		@(posedge clock);
		local_fail_in <= 1'b0;
		bus_fail <= 1'b0;
		@(negedge clock);
	endtask : kick

	// interface-node rounds
	task automatic t_round_three();
		plan(16'h5555, 4'h0, 4'hf, 4'hf, DL, 8'h55);
		round(ROUND_THREE, "r3 clean", 12'hc50);
		plan(16'h9655, 4'h8, 4'hf, 4'hf, 32'h0a0a6506, 8'h55);
		round(ROUND_THREE, "r3 mixed", 12'hc5c);
		plan(16'h0421, 4'h0, 4'hf, 4'hf, DL, 8'h15);
		round(ROUND_THREE, "r3 no majority", 12'he1e);
		restart();
		plan(16'hffff, 4'h0, 4'hf, 4'hf, DL, 8'h55);
		round(ROUND_THREE, "r3 all convicted", 12'hef0);
		restart();
		@(posedge clock);
		op_mode <= MODE_INIT;
		plan(16'h2222, 4'h0, 4'hf, 4'hf, DL, 8'h55);
		round(ROUND_THREE, "r3 self convicted", 12'hd20);
		restart();
		plan(16'h5555, 4'h0, 4'hf, 4'h0, DL, 8'h55);
		round(ROUND_THREE, "r3 no voter", 12'h200);
		restart();
	endtask : t_round_three

	// manager-node rounds
	task automatic t_manager();
		plan(16'hf653, 4'h0, 4'hf, 4'hf, 32'h050a0a0a, 8'h55);
		round(ROUND_TWO, "r2 bit vote", 12'h878);
		plan(16'h3333, 4'h4, 4'hd, 4'he, DL, 8'h95);
		round(ROUND_TWO, "r2 no voter", 12'h27c);
		restart();
		plan(16'h0000, 4'h0, 4'hd, 4'hf, DL, 8'h56);
		round(ROUND_FOUR, "r4 screen", 12'h001);
	endtask : t_manager

	task automatic t_selftest();
		int up;
		up = 0;
		kick(1'b1);
		restart();
		kick(1'b0);
		restart();
		@(posedge clock);
		test_fail <= 1'b1;
		kick(1'b0);
		repeat (80) @(negedge clock) if (bus_out_en !== 1'b0) up++;
		chk("off while test fails", up, 0);
		@(posedge clock);
		test_fail <= 1'b0;
		wait_oper();
		@(posedge clock);
		test_perm_fault <= 1'b1;
		kick(1'b0);
		repeat (30) @(negedge clock);
		@(posedge clock);
		test_perm_fault <= 1'b0;
		repeat (100) @(negedge clock) if (bus_out_en !== 1'b0) up++;
		chk("halted for good", up, 0);
		$display("done self-test");
	endtask : t_selftest

	// main sequence
	initial begin
		srst = 1'b1;
		node_is_manager = 1'b0;
		round_start = 1'b0;
		power_on_en = 1'b1;
		{bus_fail, local_fail_in, test_fail, test_perm_fault} = 4'h0;
		self_idx = 2'h1;
		op_mode = MODE_DETECT;
		round_sel = ROUND_THREE;
		{trusted, bad_link, is_data} = 12'hf0f;
		word = '0;
		dly = DL;
		cnt = 8'h55;
		do_reset(1'b0);
		t_round_three();
		do_reset(1'b1);
		t_manager();
		t_selftest();
		end_sim();
	end

	// watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge clock);
		n_errors++;
		end_sim();
	end
endmodule : cdst_node_tb_top
